// ==== core/tws_pkg.sv ====
package tws_pkg;

    // register byte offsets on the bus
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_OWN = 8'h08;
    localparam logic [7:0] OFS_DATA = 8'h0C;

    // serial_control_reg bit positions
    localparam int CTRL_LINK = 6;
    localparam int CTRL_STA = 5;
    localparam int CTRL_STO = 4;
    localparam int CTRL_FLAG = 3;
    localparam int CTRL_ACK = 2;
    localparam logic [7:0] CTRL_MASK = 8'h7C;

    // own_address_reg bit positions
    localparam int OWN_GC = 0;

    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] OWN_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;

    // status codes
    localparam logic [7:0] ST_NONE = 8'hF8;
    localparam logic [7:0] ST_OWN_W = 8'h60;
    localparam logic [7:0] ST_ARB_OWN_W = 8'h68;
    localparam logic [7:0] ST_GC = 8'h70;
    localparam logic [7:0] ST_ARB_GC = 8'h78;
    localparam logic [7:0] ST_OWN_ACK = 8'h80;
    localparam logic [7:0] ST_OWN_NACK = 8'h88;
    localparam logic [7:0] ST_GC_ACK = 8'h90;
    localparam logic [7:0] ST_GC_NACK = 8'h98;
    localparam logic [7:0] ST_STOP = 8'hA0;

    // bits per byte on the wire, counting the last one
    localparam logic [3:0] BYTE_BITS = 4'h8;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [4:0] {
        TWS_IDLE = 5'b00001,
        TWS_RX = 5'b00010,
        TWS_ACK = 5'b00100,
        TWS_WAIT = 5'b01000,
        TWS_IGNORE = 5'b10000
    } tws_state_e;

endpackage

// ==== core/tws_slave_rx.sv ====
`timescale 1ns/1ps

module tws_slave_rx
    import tws_pkg::*;
#(
    parameter int AW = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    input wire logic arb_lost,
    output logic tx_select,
    output logic start_issue
);

    if (AW < 4) begin : g_chk
        $error("tws_slave_rx: AW must be at least 4");
    end

    typedef struct packed {
        tws_state_e st;
        logic [7:0] ctrl;
        logic [7:0] own;
        logic [7:0] data;
        logic [7:0] code;
        logic [7:0] shift;
        logic [3:0] cnt;
        logic addressed;
        logic gc;
        logic lost;
        logic dphase;
        logic acked;
        logic term;
        logic start_armed;
        logic busy;
        logic scl_s1;
        logic scl_s2;
        logic scl_s3;
        logic sda_s1;
        logic sda_s2;
        logic sda_s3;
        logic scl_oe_n;
        logic sda_oe_n;
        logic tx_select;
        logic start_issue;
        logic aw_have;
        logic [AW-1:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tws_regs_s;

    tws_regs_s q;
    tws_regs_s d;

    // {hit, index}: index 0 ctrl, 1 status, 2 own address, 3 data
    function automatic logic [2:0] tws_decode(input logic [AW-1:0] a);
        logic [7:0] w;
        w = 8'(a);
        if (a[1:0] != 2'h0 || (AW > 8 && (a >> 8) != '0)) begin
            return 3'h0;
        end
        unique case (w)
            OFS_CTRL: return 3'h4;
            OFS_STAT: return 3'h5;
            OFS_OWN: return 3'h6;
            OFS_DATA: return 3'h7;
            default: return 3'h0;
        endcase
    endfunction

    always_comb begin
        logic scl_rise;
        logic scl_fall;
        logic start_c;
        logic stop_c;
        logic match_own;
        logic match_gc;
        logic [2:0] wsel;
        logic [2:0] rsel;
        logic [7:0] stat;
        scl_rise = 1'b0;
        scl_fall = 1'b0;
        start_c = 1'b0;
        stop_c = 1'b0;
        match_own = 1'b0;
        match_gc = 1'b0;
        wsel = 3'h0;
        rsel = 3'h0;
        stat = 8'h00;
        d = q;
        d.tx_select = 1'b0;
        d.start_issue = 1'b0;

        // two flops before any logic, third for edges
        d.scl_s1 = scl_i;
        d.scl_s2 = q.scl_s1;
        d.scl_s3 = q.scl_s2;
        d.sda_s1 = sda_i;
        d.sda_s2 = q.sda_s1;
        d.sda_s3 = q.sda_s2;
        scl_rise = q.scl_s2 & ~q.scl_s3;
        scl_fall = ~q.scl_s2 & q.scl_s3;
        start_c = q.scl_s2 & q.scl_s3 & q.sda_s3 & ~q.sda_s2;
        stop_c = q.scl_s2 & q.scl_s3 & ~q.sda_s3 & q.sda_s2;
        if (start_c) begin
            d.busy = 1'b1;
        end else if (stop_c) begin
            d.busy = 1'b0;
        end

        // bus write: address and data may come in either order
        if (s_axi_awvalid && q.awready) begin
            d.aw_have = 1'b1;
            d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready) begin
            d.w_have = 1'b1;
            d.w_data = s_axi_wdata;
            d.w_strb = s_axi_wstrb;
        end
        if (q.aw_have && q.w_have) begin
            wsel = tws_decode(q.aw_addr);
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = wsel[2] ? RESP_OKAY : RESP_SLVERR;
            if (wsel[2] && q.w_strb[0]) begin
                unique case (wsel[1:0])
                    2'h0: begin
                        // software may clear the flag but never set it
                        d.ctrl = q.w_data[7:0] & CTRL_MASK;
                        d.ctrl[CTRL_FLAG] = q.ctrl[CTRL_FLAG] & q.w_data[CTRL_FLAG];
                    end
                    2'h1: d.ctrl = q.ctrl;
                    2'h2: d.own = q.w_data[7:0];
                    2'h3: d.data = q.w_data[7:0];
                endcase
            end
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        d.awready = ~d.aw_have & ~d.bvalid & ~(q.aw_have & q.w_have);
        d.wready = ~d.w_have & ~d.bvalid & ~(q.aw_have & q.w_have);

        // bus read
        stat = q.ctrl[CTRL_FLAG] ? q.code : ST_NONE;
        if (s_axi_arvalid && q.arready) begin
            rsel = tws_decode(s_axi_araddr);
            d.rvalid = 1'b1;
            d.arready = 1'b0;
            d.rresp = rsel[2] ? RESP_OKAY : RESP_SLVERR;
            d.rdata = 32'h0;
            if (rsel[2]) begin
                unique case (rsel[1:0])
                    2'h0: d.rdata = {24'h0, q.ctrl};
                    2'h1: d.rdata = {24'h0, stat};
                    2'h2: d.rdata = {24'h0, q.own};
                    2'h3: d.rdata = {24'h0, q.data};
                endcase
            end
        end
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
            d.arready = 1'b1;
        end

        // start request goes out once the bus is idle
        if (q.start_armed && !q.busy) begin
            d.start_armed = 1'b0;
            d.start_issue = 1'b1;
        end

        if (!q.ctrl[CTRL_LINK]) begin
            d.st = TWS_IDLE;
            d.addressed = 1'b0;
            d.scl_oe_n = 1'b1;
            d.sda_oe_n = 1'b1;
        end else begin
            unique case (q.st)
                TWS_IDLE, TWS_IGNORE: begin
                end
                TWS_RX: begin
                    if (scl_rise) begin
                        d.shift = {q.shift[6:0], q.sda_s2};
                        d.cnt = q.cnt + 4'h1;
                    end
                    if (scl_fall && q.cnt == BYTE_BITS) begin
                        if (!q.dphase) begin
                            match_gc = (q.shift[7:1] == 7'h00) && q.own[OWN_GC];
                            match_own = (q.shift[7:1] == q.own[7:1]) && !match_gc;
                            // a deaf device still follows the bus in IGNORE
                            if (q.ctrl[CTRL_ACK] && (match_own || match_gc) && !q.shift[0]) begin
                                d.addressed = 1'b1;
                                d.gc = match_gc;
                                d.lost = arb_lost;
                                d.acked = 1'b1;
                                d.sda_oe_n = 1'b0;
                                d.st = TWS_ACK;
                            end else begin
                                d.tx_select = q.ctrl[CTRL_ACK] && match_own && q.shift[0];
                                d.st = TWS_IGNORE;
                            end
                        end else begin
                            d.data = q.shift;
                            d.acked = q.ctrl[CTRL_ACK];
                            d.sda_oe_n = ~q.ctrl[CTRL_ACK];
                            d.st = TWS_ACK;
                        end
                    end
                end
                TWS_ACK: begin
                    if (scl_fall) begin
                        d.sda_oe_n = 1'b1;
                        d.ctrl[CTRL_FLAG] = 1'b1;
                        d.scl_oe_n = 1'b0;
                        d.term = q.dphase && !q.acked;
                        d.st = TWS_WAIT;
                        if (!q.dphase) begin
                            if (q.gc) begin
                                d.code = q.lost ? ST_ARB_GC : ST_GC;
                            end else begin
                                d.code = q.lost ? ST_ARB_OWN_W : ST_OWN_W;
                            end
                        end else if (q.gc) begin
                            d.code = q.acked ? ST_GC_ACK : ST_GC_NACK;
                        end else begin
                            d.code = q.acked ? ST_OWN_ACK : ST_OWN_NACK;
                        end
                    end
                end
                TWS_WAIT: begin
                    // frozen here until software clears the flag
                    if (!q.ctrl[CTRL_FLAG]) begin
                        d.scl_oe_n = 1'b1;
                        d.cnt = 4'h0;
                        if (q.ctrl[CTRL_STO]) begin
                            d.ctrl[CTRL_STO] = 1'b0;
                            d.addressed = 1'b0;
                            d.st = TWS_IDLE;
                        end else if (q.term) begin
                            // later recognition rests on ack_enable alone
                            d.addressed = 1'b0;
                            d.start_armed = q.ctrl[CTRL_STA];
                            d.st = TWS_IDLE;
                        end else begin
                            d.dphase = 1'b1;
                            d.st = TWS_RX;
                        end
                    end
                end
                default: d.st = TWS_IDLE;
            endcase

            // while frozen, start and stop are only tracked in busy
            if ((start_c || stop_c) && q.st != TWS_WAIT) begin
                d.sda_oe_n = 1'b1;
                d.cnt = 4'h0;
                d.dphase = 1'b0;
                if (q.addressed) begin
                    d.code = ST_STOP;
                    d.ctrl[CTRL_FLAG] = 1'b1;
                    d.term = 1'b1;
                    d.st = TWS_WAIT;
                end else begin
                    d.st = start_c ? TWS_RX : TWS_IDLE;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.st <= TWS_IDLE;
            q.ctrl <= CTRL_RST;
            q.own <= OWN_RST;
            q.data <= DATA_RST;
            q.code <= ST_NONE;
            q.scl_s1 <= 1'b1;
            q.scl_s2 <= 1'b1;
            q.scl_s3 <= 1'b1;
            q.sda_s1 <= 1'b1;
            q.sda_s2 <= 1'b1;
            q.sda_s3 <= 1'b1;
            q.scl_oe_n <= 1'b1;
            q.sda_oe_n <= 1'b1;
            q.awready <= 1'b1;
            q.wready <= 1'b1;
            q.arready <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    // open-drain: the pad only ever pulls low
    assign scl_o = q.code[0];
    assign sda_o = q.code[1];
    assign scl_oe_n = q.scl_oe_n;
    assign sda_oe_n = q.sda_oe_n;
    assign tx_select = q.tx_select;
    assign start_issue = q.start_issue;

endmodule // tws_slave_rx

// ==== dv/tws_bus_master.sv ====
`timescale 1ns/1ps
module tws_bus_master (
    input wire logic scl,
    input wire logic sda,
    output logic scl_low,
    output logic sda_low
);
    // 125 ns period keeps well below the fastest rate the slave accepts
    localparam realtime HALF = 62.5;
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    task automatic start();
        sda_low = 1'b1;
        #HALF;
        scl_low = 1'b1;
    endtask
    // data only moves 20 ns after scl fell, so it is never mistaken for start or stop
    task automatic send_bit(input logic b, output logic s);
        #20;
        sda_low = !b;
        #(HALF - 20);
        scl_low = 1'b0;
        wait (scl);
        s = sda;
        #HALF;
        scl_low = 1'b1;
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            send_bit(b[i], s);
        end
        send_bit(1'b1, s);
        ack = !s;
    endtask
    task automatic stop();
        #20;
        sda_low = 1'b1;
        #(HALF - 20);
        scl_low = 1'b0;
        wait (scl);
        #HALF;
        sda_low = 1'b0;
        #HALF;
    endtask
endmodule // tws_bus_master

// ==== dv/tws_slave_rx_chk.sv ====
`timescale 1ns/1ps
module tws_slave_rx_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic scl_oe_n,
    input wire logic sda_oe_n,
    input wire logic tx_select,
    input wire logic start_issue
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_STRETCH_HOLD: assert property ($fell(scl_oe_n) |=> !scl_oe_n [*3])
        else $error("stretch ended early");
    AST_STRETCH_END: assert property ($rose(scl_oe_n) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
        else $error("stretch ended without a write");
    AST_ACK_AT_LOW: assert property ($fell(sda_oe_n) |-> !scl_i && !$past(scl_i, 2))
        else $error("ack driven while clock high");
    AST_ACK_HOLD: assert property ($fell(sda_oe_n) |=> !sda_oe_n [*8])
        else $error("ack too short");
    AST_ACK_NO_STRETCH: assert property (!sda_oe_n |-> scl_oe_n)
        else $error("stretch during ack");
    AST_TX_PULSE: assert property (tx_select |-> scl_oe_n ##1 !tx_select)
        else $error("handoff pulse wrong");
    AST_START_FREE: assert property (start_issue |-> scl_i && sda_i ##1 !start_issue)
        else $error("start while bus busy");
endmodule // tws_slave_rx_chk

bind tws_slave_rx tws_slave_rx_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .scl_i, .sda_i, .scl_oe_n,
    .sda_oe_n, .tx_select, .start_issue);

// ==== dv/tws_slave_rx_test.sv ====
`timescale 1ns/1ps
module tws_slave_rx_test;
    import tws_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, arb_lost = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic scl_o, scl_oe_n, sda_o, sda_oe_n, tx_select, start_issue, m_scl_low, m_sda_low, scl, sda, ack;
    logic [6:0] own_a;
    logic [7:0] ctl = 8'h00;
    int failures = 0, n_checks = 0, n_start = 0, n_tx = 0;
    integer seed = 36;
    // open-drain wires with pull-ups
    assign scl = m_scl_low ? 1'b0 : (scl_oe_n ? 1'b1 : scl_o);
    assign sda = m_sda_low ? 1'b0 : (sda_oe_n ? 1'b1 : sda_o);
    always #5 aclk = ~aclk;
    always @(posedge aclk) begin
        if (start_issue === 1'b1) n_start++;
        if (tx_select === 1'b1) n_tx++;
    end
    tws_slave_rx dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .scl_i(scl), .scl_o, .scl_oe_n, .sda_i(sda), .sda_o, .sda_oe_n, .arb_lost,
        .tx_select, .start_issue);
    tws_bus_master m (.scl, .sda, .scl_low(m_scl_low), .sda_low(m_sda_low));
    task automatic chk(input string n, input logic [33:0] seen, input logic [33:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %0h seen %0h", n, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        if (a == OFS_CTRL) ctl = v[7:0] & CTRL_MASK & 8'hF7;
        chk("bresp", 34'(s_axi_bresp), 34'(RESP_OKAY));
    endtask
    task automatic rdx(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk($sformatf("reg %0h", a), {s_axi_rresp, s_axi_rdata}, {er, e});
    endtask
    // one byte from the master, then status, flag and stretch as the slave must show them
    task automatic step(input logic [7:0] b, input logic ea, input logic [7:0] code);
        m.send_byte(b, ack);
        repeat (10) @(posedge aclk);
        chk("ack", 34'(ack), 34'(ea));
        rdx(OFS_STAT, {24'h0, code}, RESP_OKAY);
        rdx(OFS_CTRL, {24'h0, ctl | (code != ST_NONE ? 8'h08 : 8'h00)}, RESP_OKAY);
        chk("scl_oe_n", 34'(scl_oe_n), 34'(code == ST_NONE));
        chk("pin_levels", 34'({scl_o, sda_o}), 34'h0);
    endtask
    task automatic test_done();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        #400000;
        failures++;
        test_done();
    end
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rdx(OFS_CTRL, 32'h0, RESP_OKAY);
        rdx(OFS_OWN, 32'h0, RESP_OKAY);
        rdx(OFS_DATA, 32'h0, RESP_OKAY);
        rdx(OFS_STAT, 32'hF8, RESP_OKAY);
        rdx(8'h10, 32'h0, RESP_SLVERR);
        wr(OFS_STAT, 32'h55);
        rdx(OFS_STAT, 32'hF8, RESP_OKAY);
        d = $random(seed);
        own_a = d[6:0] | 7'h01;
        wr(OFS_OWN, {24'h0, own_a, 1'b1});
        wr(OFS_CTRL, 32'h44);
        $display("test registers done");
        for (int k = 0; k < 4; k++) begin
            @(posedge aclk);
            arb_lost <= k[1];
            d = $random(seed);
            m.start();
            step(k[0] ? 8'h00 : {own_a, 1'b0}, 1'b1, 8'(8'h60 + 16 * k[0] + 8 * k[1]));
            wr(OFS_CTRL, 32'h44);
            step(d[7:0], 1'b1, k[0] ? ST_GC_ACK : ST_OWN_ACK);
            rdx(OFS_DATA, {24'h0, d[7:0]}, RESP_OKAY);
            wr(OFS_CTRL, 32'h40);
            step(d[15:8], 1'b0, k[0] ? ST_GC_NACK : ST_OWN_NACK);
            rdx(OFS_DATA, {24'h0, d[15:8]}, RESP_OKAY);
            wr(OFS_CTRL, 32'h44);
            m.stop();
        end
        arb_lost <= 1'b0;
        $display("test receive done");
        m.start();
        step({own_a, 1'b0}, 1'b1, ST_OWN_W);
        wr(OFS_CTRL, 32'h40);
        step(8'hA5, 1'b0, ST_OWN_NACK);
        wr(OFS_CTRL, 32'h40);
        m.stop();
        m.start();
        step({own_a, 1'b0}, 1'b0, ST_NONE);
        m.stop();
        wr(OFS_CTRL, 32'h44);
        m.start();
        step({own_a, 1'b0}, 1'b1, ST_OWN_W);
        wr(OFS_CTRL, 32'h64);
        m.stop();
        repeat (10) @(posedge aclk);
        rdx(OFS_STAT, {24'h0, ST_STOP}, RESP_OKAY);
        chk("scl_oe_n", 34'(scl_oe_n), 34'h1);
        wr(OFS_CTRL, 32'h64);
        repeat (20) @(posedge aclk);
        chk("start_issue", 34'(n_start), 34'h1);
        wr(OFS_CTRL, 32'h44);
        // stop_request with the flag cleared drops the address and clears itself
        m.start();
        step({own_a, 1'b0}, 1'b1, ST_OWN_W);
        wr(OFS_CTRL, 32'h54);
        rdx(OFS_CTRL, 32'h44, RESP_OKAY);
        rdx(OFS_STAT, 32'hF8, RESP_OKAY);
        wr(OFS_CTRL, 32'h44);
        m.stop();
        $display("test stop done");
        wr(OFS_OWN, {24'h0, own_a, 1'b0});
        m.start();
        step(8'h00, 1'b0, ST_NONE);
        m.stop();
        m.start();
        m.send_byte({own_a, 1'b1}, ack);
        repeat (10) @(posedge aclk);
        chk("tx_select", 34'(n_tx), 34'h1);
        rdx(OFS_STAT, 32'hF8, RESP_OKAY);
        m.stop();
        $display("test ignore done");
        test_done();
    end
endmodule // tws_slave_rx_test
